// ### stc_tick_defs.svh
// Behaviour
// - At zero the count reloads from the 24-bit wrap value and keeps counting.
// - Live count reads the 24-bit count in bits 23-0, upper bits zero.
// - Any write to the live count clears it to zero, data ignored.
// - That clearing write also clears the zero-reached flag.
// - Calibration bit 31 reads 0 with reference clock, 1 without.
// - Calibration bit 30 reads 0 when the calibration gives exactly 10 ms.
// - Calibration bits 23-0 read 0x9C4, the 10 ms wrap value, from reset.
// - Zero-reached flag reads 1 if zero reached since last read; reads clear it.
// - Enabling loads the count from the wrap value and starts; 0 stops it.
// - Source select 0 counts oscillator over 32, 1 counts the CPU clock.
// - With interrupt enable set, reaching zero pends a tick exception.
`ifndef STC_TICK_DEFS_SVH
`define STC_TICK_DEFS_SVH

// ============================================================
// Register byte offsets
`define STC_OFF_CTRL 8'h00
`define STC_OFF_WRAP 8'h04
`define STC_OFF_LIVE 8'h08
`define STC_OFF_CALIB 8'h0c

// ============================================================
// Control and status fields
`define STC_CTRL_ENABLE 0
`define STC_CTRL_IRQ_EN 1
`define STC_CTRL_SRC_SEL 2
`define STC_CTRL_ZERO_FLAG 16

// ============================================================
// Calibration fields and values
`define STC_CAL_REF_ABSENT 31
`define STC_CAL_INEXACT 30
`define STC_CAL_TEN_MILLI 24'h0009c4

// ============================================================
// Widths, reset values and timing counts
`define STC_CNT_W 24
`define STC_REF_DIV 32
`define STC_CNT_RESET 24'h000000
`define STC_WRAP_RESET 24'h000000

`endif

// ### stc_tick_pkg.sv
package stc_tick_pkg;

    // Register selected by the bus address
    typedef enum logic [2:0] {
        STC_SEL_CTRL = 3'b000,
        STC_SEL_WRAP = 3'b001,
        STC_SEL_LIVE = 3'b010,
        STC_SEL_CALIB = 3'b011,
        STC_SEL_NONE = 3'b100
    } stc_sel_t;

endpackage

// ### stc_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

interface stc_tick_if;
    logic tick;

    modport src (
        output tick
    );

    modport snk (
        input tick
    );
endinterface

`default_nettype wire

// ### stc_ref_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "stc_tick_defs.svh"

// Turns the oscillator pin into one-cycle ticks at oscillator rate over the divisor
module stc_ref_tick #(
    parameter int DIV = `STC_REF_DIV
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic REF_CLK,
    stc_tick_if.src tick_o
);
    localparam int DW = $clog2(DIV);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic [DW-1:0] div_q;
    logic tick_q;
    logic rise;

    // ============================================================
    // Two-stage synchroniser
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (CE) begin
            sync1_q <= REF_CLK;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign rise = sync2_q & ~prev_q;

    // ============================================================
    // Divider
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else if (CE) begin
            tick_q <= 1'b0;
            if (rise) begin
                if (div_q == DW'(DIV - 1)) begin
                    div_q <= '0;
                    tick_q <= 1'b1;
                end else begin
                    div_q <= div_q + DW'(1);
                end
            end
        end
    end

    assign tick_o.tick = tick_q;
endmodule

`default_nettype wire

// ### stc_tick_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "stc_tick_defs.svh"

module stc_tick_top #(
    parameter int CNT_W = `STC_CNT_W,
    parameter logic REF_CLOCK_ABSENT = 1'b0,
    parameter logic CALIB_INEXACT = 1'b0
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic REF_CLK,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic TICK_PEND
);

    // ============================================================
    // Declarations
    stc_tick_if ref_if ();

    logic ack_q;
    logic ack_d;
    logic req;
    logic wr_fire;
    logic rd_fire;
    stc_tick_pkg::stc_sel_t sel;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    logic enable_q;
    logic irq_en_q;
    logic src_sel_q;
    logic zero_flag_q;
    logic [CNT_W-1:0] wrap_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic pend_q;

    logic tick;
    logic start;
    logic live_clear;
    logic hit_zero;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_new;
    logic [31:0] wrap_new;

    // ============================================================
    // Helpers
    function automatic stc_tick_pkg::stc_sel_t decode(input logic [7:0] addr);
        case (addr)
            `STC_OFF_CTRL: decode = stc_tick_pkg::STC_SEL_CTRL;
            `STC_OFF_WRAP: decode = stc_tick_pkg::STC_SEL_WRAP;
            `STC_OFF_LIVE: decode = stc_tick_pkg::STC_SEL_LIVE;
            `STC_OFF_CALIB: decode = stc_tick_pkg::STC_SEL_CALIB;
            default: decode = stc_tick_pkg::STC_SEL_NONE;
        endcase
    endfunction

    // Merge write data into an old word under the byte enables
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        merge = res;
    endfunction

    function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
        logic [31:0] w;
        w = '0;
        w[CNT_W-1:0] = v;
        widen = w;
    endfunction

    // ============================================================
    // Reference tick source
    stc_ref_tick #(
        .DIV(`STC_REF_DIV)
    ) u_ref (
        .CLK(CLK),
        .RST_B(RST_B),
        .CE(CE),
        .REF_CLK(REF_CLK),
        .tick_o(ref_if)
    );

    assign tick = src_sel_q ? 1'b1 : ref_if.tick;

    // ============================================================
    // Avalon slave: one wait state on every access
    assign req = AVS_READ | AVS_WRITE;
    assign ack_d = req & ~ack_q;
    assign AVS_WAITREQUEST = req & ~ack_q;
    assign sel = decode(AVS_ADDRESS);
    assign wr_fire = AVS_WRITE & ack_q & CE;
    // Read side effects happen when the data is captured
    assign rd_fire = AVS_READ & ~ack_q & CE;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ack_q <= 1'b0;
        end else if (CE) begin
            ack_q <= ack_d;
        end
    end

    assign ctrl_word = {15'h0000, zero_flag_q, 13'h0000, src_sel_q, irq_en_q, enable_q};

    always_comb begin
        rdata_d = 32'h00000000;
        case (sel)
            stc_tick_pkg::STC_SEL_CTRL: rdata_d = ctrl_word;
            stc_tick_pkg::STC_SEL_WRAP: rdata_d = widen(wrap_q);
            stc_tick_pkg::STC_SEL_LIVE: rdata_d = widen(count_q);
            stc_tick_pkg::STC_SEL_CALIB: begin
                rdata_d[`STC_CAL_REF_ABSENT] = REF_CLOCK_ABSENT;
                rdata_d[`STC_CAL_INEXACT] = CALIB_INEXACT;
                rdata_d[23:0] = `STC_CAL_TEN_MILLI;
            end
            default: rdata_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rdata_q <= 32'h00000000;
        end else if (rd_fire) begin
            rdata_q <= rdata_d;
        end
    end

    assign AVS_READDATA = rdata_q;

    // ============================================================
    // Control and wrap registers
    assign ctrl_new = merge(ctrl_word, AVS_WRITEDATA, AVS_BYTEENABLE);
    assign wrap_new = merge(widen(wrap_q), AVS_WRITEDATA, AVS_BYTEENABLE);
    assign start = wr_fire && sel == stc_tick_pkg::STC_SEL_CTRL
        && ctrl_new[`STC_CTRL_ENABLE] && !enable_q;
    assign live_clear = wr_fire && sel == stc_tick_pkg::STC_SEL_LIVE;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            enable_q <= 1'b0;
            irq_en_q <= 1'b0;
            src_sel_q <= 1'b0;
        end else if (wr_fire && sel == stc_tick_pkg::STC_SEL_CTRL) begin
            enable_q <= ctrl_new[`STC_CTRL_ENABLE];
            irq_en_q <= ctrl_new[`STC_CTRL_IRQ_EN];
            src_sel_q <= ctrl_new[`STC_CTRL_SRC_SEL];
        end
    end

    // Software is expected to write calibration minus one for a periodic tick
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            wrap_q <= `STC_WRAP_RESET;
        end else if (wr_fire && sel == stc_tick_pkg::STC_SEL_WRAP) begin
            wrap_q <= wrap_new[CNT_W-1:0];
        end
    end

    // ============================================================
    // Down-counter
    assign hit_zero = enable_q && tick && !start && !live_clear && count_q == CNT_W'(1);

    always_comb begin
        count_d = count_q;
        if (live_clear) begin
            count_d = '0;
        end else if (start) begin
            count_d = wrap_q;
        end else if (enable_q && tick) begin
            if (count_q == '0) begin
                count_d = wrap_q;
            end else begin
                count_d = count_q - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            count_q <= `STC_CNT_RESET;
        end else if (CE) begin
            count_q <= count_d;
        end
    end

    // ============================================================
    // Zero-reached flag and exception pend
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            zero_flag_q <= 1'b0;
        end else if (CE) begin
            if (hit_zero) begin
                zero_flag_q <= 1'b1;
            end else if (live_clear) begin
                zero_flag_q <= 1'b0;
            end else if (rd_fire && sel == stc_tick_pkg::STC_SEL_CTRL) begin
                zero_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pend_q <= 1'b0;
        end else if (CE) begin
            pend_q <= hit_zero & irq_en_q;
        end
    end

    assign TICK_PEND = pend_q;
endmodule

`default_nettype wire

// ### stc_tick_dummy_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### stc_tick_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module stc_tick_asserts (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic REF_CLK,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic TICK_PEND
);
    // ==========================================
    // Bus and counter checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    wire logic rq = AVS_READ | AVS_WRITE;
    wire logic rack = AVS_READ & !AVS_WAITREQUEST;
    wire logic wack = AVS_WRITE & !AVS_WAITREQUEST;
    AST_ONE_WAIT: assert property (rq && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("wait state longer than one cycle");
    AST_IDLE_NO_WAIT: assert property (!rq |-> !AVS_WAITREQUEST)
        else $error("waitrequest without request");
    AST_LIVE_UPPER: assert property (
        rack && AVS_ADDRESS == 8'h08 |-> AVS_READDATA[31:24] == 8'h00)
        else $error("live count upper bits set");
    AST_WRAP_UPPER: assert property (
        rack && AVS_ADDRESS == 8'h04 |-> AVS_READDATA[31:24] == 8'h00)
        else $error("wrap upper bits set");
    AST_CALIB_WORD: assert property (
        rack && AVS_ADDRESS == 8'h0c |-> AVS_READDATA == 32'h000009c4)
        else $error("calibration word wrong");
    AST_UNMAPPED_ZERO: assert property (
        rack && !(AVS_ADDRESS inside {8'h00, 8'h04, 8'h08, 8'h0c}) |-> AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    AST_CLEAR_NO_PEND: assert property (
        wack && AVS_ADDRESS == 8'h08 |=> !TICK_PEND [*2])
        else $error("pend after live count clear");
    AST_PEND_PULSE: assert property (TICK_PEND |=> !TICK_PEND)
        else $error("pend longer than one cycle");
    AST_RDATA_HOLD: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
        else $error("read data changed without read");
endmodule
`default_nettype wire

// ### stc_tick_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stc_tick_top_tb;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic CE = 1'b1;
    logic REF_CLK = 1'b0;
    logic [7:0] AVS_ADDRESS = 8'h00;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0] AVS_BYTEENABLE = 4'hf;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic TICK_PEND;
    int n_fail = 0;
    int n_checks = 0;
    int n_pend = 0;
    int base;
    logic [31:0] rd;
    logic [31:0] rd2;
    stc_tick_top stc_tick_top_i (.CLK(CLK), .RST_B(RST_B), .CE(CE), .REF_CLK(REF_CLK),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .TICK_PEND(TICK_PEND));
    always #2.5 CLK = ~CLK;
    always @(posedge CLK) if (TICK_PEND === 1'b1) n_pend++;
    // ==========================================
    // Bus tasks
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_READ <= !wr;
        AVS_WRITE <= wr;
        @(posedge CLK);
        while (AVS_WAITREQUEST !== 1'b0 && n < 20) begin
            @(posedge CLK);
            n++;
        end
        if (AVS_WAITREQUEST !== 1'b0) n_fail++;
        rd = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic refp(input int n);
        repeat (n) begin
            repeat (2) @(posedge CLK);
            REF_CLK <= 1'b1;
            repeat (2) @(posedge CLK);
            REF_CLK <= 1'b0;
        end
        repeat (6) @(posedge CLK);
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        repeat (5000) @(posedge CLK);
        n_fail++;
        stop_test;
    end
    initial begin
        repeat (6) @(posedge CLK);
        RST_B <= 1'b1;
        rdchk("ctrl", 8'h00, 32'h0);
        rdchk("wrap", 8'h04, 32'h0);
        rdchk("live", 8'h08, 32'h0);
        rdchk("calib", 8'h0c, 32'h000009c4);
        xfer(1'b1, 8'h10, 32'hffffffff);
        rdchk("unmapped", 8'h10, 32'h0);
        xfer(1'b1, 8'h04, 32'hffffffff);
        rdchk("wrap", 8'h04, 32'h00ffffff);
        xfer(1'b1, 8'h04, 32'h000009c3);
        rdchk("wrap", 8'h04, 32'h000009c3);
        AVS_BYTEENABLE <= 4'h2;
        xfer(1'b1, 8'h04, 32'hffffffff);
        AVS_BYTEENABLE <= 4'hf;
        rdchk("wrap bytes", 8'h04, 32'h0000ffc3);
        $display("test registers done");
        xfer(1'b1, 8'h04, 32'h5);
        xfer(1'b1, 8'h00, 32'h1);
        rdchk("live", 8'h08, 32'h5);
        refp(32);
        rdchk("live", 8'h08, 32'h4);
        refp(160);
        rdchk("live", 8'h08, 32'h5);
        rdchk("ctrl", 8'h00, 32'h00010001);
        rdchk("ctrl", 8'h00, 32'h1);
        refp(160);
        xfer(1'b1, 8'h08, 32'hdeadbeef);
        rdchk("live", 8'h08, 32'h0);
        rdchk("ctrl", 8'h00, 32'h1);
        $display("test reference source done");
        xfer(1'b1, 8'h04, 32'h3);
        xfer(1'b1, 8'h00, 32'h7);
        repeat (40) @(posedge CLK);
        xfer(1'b1, 8'h00, 32'h6);
        chk("pend seen", 32'h1, n_pend > 0);
        xfer(1'b0, 8'h08, 32'h0);
        rd2 = rd;
        rdchk("live held", 8'h08, rd2);
        rdchk("ctrl", 8'h00, 32'h00010006);
        base = n_pend;
        xfer(1'b1, 8'h00, 32'h5);
        repeat (40) @(posedge CLK);
        xfer(1'b1, 8'h00, 32'h4);
        chk("pend masked", base, n_pend);
        $display("test cpu clock source done");
        xfer(1'b1, 8'h04, 32'h00000fff);
        xfer(1'b1, 8'h00, 32'h5);
        xfer(1'b0, 8'h08, 32'h0);
        rd2 = rd;
        CE <= 1'b0;
        repeat (20) @(posedge CLK);
        CE <= 1'b1;
        xfer(1'b0, 8'h08, 32'h0);
        chk("frozen count step", 32'h3, rd2 - rd);
        $display("test clock enable done");
        RST_B <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        rdchk("ctrl after reset", 8'h00, 32'h0);
        rdchk("live after reset", 8'h08, 32'h0);
        rdchk("wrap after reset", 8'h04, 32'h0);
        rdchk("calib after reset", 8'h0c, 32'h000009c4);
        $display("test mid-run reset done");
        stop_test;
    end
endmodule
bind stc_tick_top stc_tick_asserts stc_tick_asserts_i (.CLK(CLK), .RST_B(RST_B), .CE(CE),
    .REF_CLK(REF_CLK), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TICK_PEND(TICK_PEND));
`default_nettype wire
